// File: address_map_pkg.sv
package address_map_pkg;

	// Program memory map
	localparam int          FLASH_BYTES      = 65536;
	localparam logic [15:0] RESET_VECTOR     = 16'h0100;
	localparam logic [15:0] VECTOR_AREA_END  = 16'h00FF;
	localparam logic [15:0] OPTION_AREA_LO   = 16'h003C;
	localparam logic [15:0] OPTION_AREA_HI   = 16'h003F;
	localparam logic [15:0] OPTION_CTRL_ADDR = 16'h003E;
	localparam logic [15:0] OPTION_AUX_ADDR  = 16'h003F;
	localparam logic [15:0] BOOT_AREA_START  = 16'h0100;
	localparam logic [15:0] BOOT_END_SMALL   = 16'h04FF;
	localparam logic [15:0] BOOT_END_LARGE   = 16'h08FF;
	localparam logic [15:0] BOOT_VEC_SMALL   = 16'h0500;
	localparam logic [15:0] BOOT_VEC_LARGE   = 16'h0900;
	localparam logic [7:0]  ERASED_BYTE      = 8'hFF;

	// Option control byte fields
	localparam int OPT_BOOT_VEC_BIT = 7;
	localparam int OPT_PROTECT_BIT  = 2;
	localparam int OPT_SIZE_BIT     = 0;
	localparam logic [7:0] OPTION_RESET = 8'hFF;

	// Register file map
	localparam logic [7:0] SET1_BASE        = 8'hC0;
	localparam logic [7:0] SYSTEM_BASE      = 8'hD0;
	localparam logic [7:0] BANK_BASE        = 8'hE0;
	localparam logic [7:0] PAGE_SELECT_ADDR = 8'hDF;
	localparam logic [7:0] PAGE_SELECT_RST  = 8'h00;
	localparam logic [7:0] DISPLAY_BYTES    = 8'h46;
	localparam logic [3:0] DISPLAY_PAGE     = 4'h8;
	localparam logic [3:0] LAST_RAM_PAGE    = 4'h7;

	// Storage layout of the register array
	localparam int PRIME_BYTES  = 192;
	localparam int SET2_BYTES   = 64;
	localparam int SET2_OFFSET  = 1536;
	localparam int DISP_OFFSET  = 2048;
	localparam int COMMON_OFFSET = 2118;
	localparam int BANK_OFFSET  = 2150;
	localparam int BANK_BYTES   = 32;
	localparam int REG_STORE    = 2214;

	typedef enum logic [2:0] {
		MODE_REGISTER     = 3'b000,
		MODE_WORKING      = 3'b001,
		MODE_INDIRECT_REG = 3'b010,
		MODE_INDEXED      = 3'b011,
		MODE_DIRECT_ADDR  = 3'b100,
		MODE_RELATIVE     = 3'b101,
		MODE_IMMEDIATE    = 3'b110
	} addr_mode_t;

	typedef enum logic [1:0] {
		BOOT_READ_CTRL = 2'b00,
		BOOT_READ_AUX  = 2'b01,
		BOOT_RUN       = 2'b10
	} boot_state_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic       is_dst;
		addr_mode_t mode;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        erase;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} pm_req_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  data;
	} prog_req_t;

endpackage : address_map_pkg

// File: register_file_address_map.sv
`timescale 1ns/1ps
`default_nettype none
module register_file_address_map (
	input  wire logic                       i_clock,
	input  wire logic                       i_sys_rst,
	input  wire logic                       i_clock_en,
	input  wire address_map_pkg::reg_req_t  i_reg_req,
	input  wire logic                       i_select_bank_zero_op,
	input  wire logic                       i_select_bank_one_op,
	input  wire address_map_pkg::pm_req_t   i_pm_req,
	input  wire address_map_pkg::prog_req_t i_prog_req,
	output logic [7:0]                      o_reg_rdata,
	output logic                            o_reg_ack,
	output logic                            o_reg_unmapped,
	output logic [7:0]                      o_register_page_select,
	output logic                            o_bank,
	output logic [7:0]                      o_pm_rdata,
	output logic                            o_pm_ack,
	output logic                            o_pm_refused,
	output logic                            o_pm_vector_area,
	output logic                            o_pm_ready,
	output logic [15:0]                     o_start_addr,
	output logic                            o_start_valid,
	output logic [7:0]                      o_option_ctrl,
	output logic [7:0]                      o_option_aux
);
	import address_map_pkg::*;

	typedef struct packed {
		boot_state_t boot;
		logic [7:0]  opt_ctrl;
		logic [7:0]  opt_aux;
		logic [7:0]  page;
		logic        bank;
		logic [7:0]  reg_rdata;
		logic        reg_ack;
		logic        reg_unmapped;
		logic [7:0]  pm_rdata;
		logic        pm_ack;
		logic        pm_refused;
		logic        pm_vector;
		logic [15:0] start_addr;
		logic        start_valid;
	} state_t;

	localparam state_t STATE_RESET = '{
		boot: BOOT_READ_CTRL, opt_ctrl: OPTION_RESET, opt_aux: OPTION_RESET,
		page: PAGE_SELECT_RST, bank: 1'b0, reg_rdata: 8'h00, reg_ack: 1'b0,
		reg_unmapped: 1'b0, pm_rdata: 8'h00, pm_ack: 1'b0, pm_refused: 1'b0,
		pm_vector: 1'b0, start_addr: RESET_VECTOR, start_valid: 1'b0};

	// Flash program memory and register storage
	logic [7:0] flash_mem [0:FLASH_BYTES-1];
	logic [7:0] reg_mem   [0:REG_STORE-1];

	state_t      s_q;
	state_t      s_d;
	logic        reg_hit;
	logic        reg_is_page;
	logic [11:0] reg_idx;
	logic        reg_we;
	logic        pm_we;
	logic [7:0]  pm_wbyte;
	logic [15:0] pm_addr_eff;

	// Boot area end for the active options; set by the size bit alone, protect bit not read
	function automatic logic [15:0] boot_end(input logic [7:0] ctrl);
		if (ctrl[OPT_SIZE_BIT] == 1'b0) begin
			boot_end = BOOT_END_SMALL;
		end else begin
			boot_end = BOOT_END_LARGE;
		end
	endfunction : boot_end

	// Start address chosen by the option control byte
	function automatic logic [15:0] start_vector(input logic [7:0] ctrl);
		if (ctrl[OPT_BOOT_VEC_BIT]) begin
			start_vector = RESET_VECTOR;
		end else if (ctrl[OPT_SIZE_BIT] == 1'b0) begin
			start_vector = BOOT_VEC_SMALL;
		end else begin
			start_vector = BOOT_VEC_LARGE;
		end
	endfunction : start_vector

	// True when a program write falls in a protected boot area
	function automatic logic boot_locked(input logic [7:0] ctrl, input logic [15:0] addr);
		if (ctrl[OPT_PROTECT_BIT]) begin
			boot_locked = 1'b0;
		end else begin
			boot_locked = (addr >= BOOT_AREA_START) && (addr <= boot_end(ctrl));
		end
	endfunction : boot_locked

	// Register address decode: steer by mode, page and bank
	always_comb begin
		logic [3:0] pg;
		logic [7:0] a;
		pg          = i_reg_req.is_dst ? s_q.page[7:4] : s_q.page[3:0];
		a           = i_reg_req.addr;
		reg_hit     = 1'b0;
		reg_is_page = 1'b0;
		reg_idx     = 12'h000;
		if (a < SET1_BASE) begin
			// Prime area, every mode; pages 0-7 plus display page
			if (pg <= LAST_RAM_PAGE) begin
				reg_hit = 1'b1;
				reg_idx = 12'(pg * PRIME_BYTES) + 12'(a);
			end else if (pg == DISPLAY_PAGE && a < DISPLAY_BYTES) begin
				reg_hit = 1'b1;
				reg_idx = 12'(DISP_OFFSET) + 12'(a);
			end
		end else if (i_reg_req.mode == MODE_INDIRECT_REG || i_reg_req.mode == MODE_INDEXED) begin
			// Set 2, one copy per RAM page
			if (pg <= LAST_RAM_PAGE) begin
				reg_hit = 1'b1;
				reg_idx = 12'(SET2_OFFSET) + 12'(pg * SET2_BYTES) + 12'(a - SET1_BASE);
			end
		end else if (i_reg_req.mode == MODE_REGISTER || i_reg_req.mode == MODE_WORKING) begin
			// Set 1, independent of the page
			if (a == PAGE_SELECT_ADDR) begin
				reg_hit     = 1'b1;
				reg_is_page = 1'b1;
			end else if (a >= BANK_BASE) begin
				reg_hit = 1'b1;
				reg_idx = 12'(BANK_OFFSET) + 12'(s_q.bank ? BANK_BYTES : 0) + 12'(a - BANK_BASE);
			end else if (a >= SYSTEM_BASE || i_reg_req.mode == MODE_WORKING) begin
				reg_hit = 1'b1;
				reg_idx = 12'(COMMON_OFFSET) + 12'(a - SET1_BASE);
			end
		end
		// Other modes at C0H-FFH stay unmapped
	end

	// Next-state logic
	always_comb begin
		logic [15:0] boot_addr;
		logic        pm_locked;
		logic        pm_option;
		boot_addr = (s_q.boot == BOOT_READ_CTRL) ? OPTION_CTRL_ADDR : OPTION_AUX_ADDR;
		s_d       = s_q;
		s_d.reg_ack    = 1'b0;
		s_d.pm_ack     = 1'b0;
		s_d.pm_refused = 1'b0;
		pm_addr_eff    = (s_q.boot == BOOT_RUN) ? i_pm_req.addr : boot_addr;
		pm_option      = (i_pm_req.addr >= OPTION_AREA_LO) && (i_pm_req.addr <= OPTION_AREA_HI);
		pm_locked      = boot_locked(s_q.opt_ctrl, i_pm_req.addr);
		pm_we          = 1'b0;
		pm_wbyte       = i_pm_req.erase ? ERASED_BYTE : i_pm_req.wdata;
		reg_we         = 1'b0;

		// Startup: latch the control byte, then the aux byte in the same cycle as the start address is published
		case (s_q.boot)
			BOOT_READ_CTRL: begin
				s_d.opt_ctrl = flash_mem[OPTION_CTRL_ADDR];
				s_d.boot     = BOOT_READ_AUX;
			end
			BOOT_READ_AUX: begin
				s_d.opt_aux     = flash_mem[OPTION_AUX_ADDR];
				s_d.start_addr  = start_vector(s_q.opt_ctrl);
				s_d.start_valid = 1'b1;
				s_d.boot        = BOOT_RUN;
			end
			default: begin
				s_d.boot = BOOT_RUN;
			end
		endcase

		// Program memory read, write and erase
		if (s_q.boot == BOOT_RUN) begin
			if (i_pm_req.wr || i_pm_req.erase) begin
				s_d.pm_ack     = 1'b1;
				s_d.pm_refused = pm_locked;
				pm_we          = !pm_locked;   // Option area write leaves s_q.opt_* alone
				s_d.pm_vector  = (i_pm_req.addr <= VECTOR_AREA_END) && !pm_option;
			end else if (i_pm_req.rd) begin
				s_d.pm_ack    = 1'b1;
				s_d.pm_rdata  = flash_mem[i_pm_req.addr];
				s_d.pm_vector = (i_pm_req.addr <= VECTOR_AREA_END);
			end
		end

		// External programmer also sets the active startup options
		if (i_prog_req.wr && i_prog_req.addr == OPTION_CTRL_ADDR) begin
			s_d.opt_ctrl = i_prog_req.data;
		end
		if (i_prog_req.wr && i_prog_req.addr == OPTION_AUX_ADDR) begin
			s_d.opt_aux = i_prog_req.data;
		end

		// Bank select; a one op wins over a zero op in the same cycle
		if (i_select_bank_one_op) begin
			s_d.bank = 1'b1;
		end else if (i_select_bank_zero_op) begin
			s_d.bank = 1'b0;
		end

		// Register access
		if (i_reg_req.valid) begin
			s_d.reg_ack      = 1'b1;
			s_d.reg_unmapped = !reg_hit;
			if (i_reg_req.write) begin
				s_d.reg_rdata = 8'h00;
				if (reg_is_page) begin
					s_d.page = i_reg_req.wdata;
				end else begin
					reg_we = reg_hit;
				end
			end else if (reg_is_page) begin
				s_d.reg_rdata = s_q.page;
			end else if (reg_hit) begin
				s_d.reg_rdata = reg_mem[reg_idx];
			end else begin
				s_d.reg_rdata = 8'h00;
			end
		end
	end

	// State register
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_q <= STATE_RESET;
		end else if (i_clock_en) begin
			s_q <= s_d;
		end
	end

	// Storage writes; programmer port has priority over CPU writes
	always_ff @(posedge i_clock) begin
		if (i_clock_en) begin
			if (i_prog_req.wr) begin
				flash_mem[i_prog_req.addr] <= i_prog_req.data;
			end else if (pm_we) begin
				flash_mem[pm_addr_eff] <= pm_wbyte;
			end
			if (reg_we) begin
				reg_mem[reg_idx] <= i_reg_req.wdata;
			end
		end
	end

	// Output drive
	assign o_reg_rdata            = s_q.reg_rdata;
	assign o_reg_ack              = s_q.reg_ack;
	assign o_reg_unmapped         = s_q.reg_unmapped;
	assign o_register_page_select = s_q.page;
	assign o_bank                 = s_q.bank;
	assign o_pm_rdata             = s_q.pm_rdata;
	assign o_pm_ack               = s_q.pm_ack;
	assign o_pm_refused           = s_q.pm_refused;
	assign o_pm_vector_area       = s_q.pm_vector;
	assign o_pm_ready             = (s_q.boot == BOOT_RUN);
	assign o_start_addr           = s_q.start_addr;
	assign o_start_valid          = s_q.start_valid;
	assign o_option_ctrl          = s_q.opt_ctrl;
	assign o_option_aux           = s_q.opt_aux;

endmodule : register_file_address_map
`default_nettype wire

// File: register_file_address_map_checker.sv
`timescale 1ns/1ps
`default_nettype none
module register_file_address_map_checker (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_clock_en,
	input wire address_map_pkg::reg_req_t i_reg_req,
	input wire logic i_select_bank_one_op,
	input wire address_map_pkg::pm_req_t i_pm_req,
	input wire address_map_pkg::prog_req_t i_prog_req,
	input wire logic o_reg_ack,
	input wire logic [7:0] o_register_page_select,
	input wire logic o_bank,
	input wire logic o_pm_ack,
	input wire logic o_pm_refused,
	input wire logic o_pm_vector_area,
	input wire logic o_pm_ready,
	input wire logic [15:0] o_start_addr,
	input wire logic o_start_valid,
	input wire logic [7:0] o_option_ctrl
);
	import address_map_pkg::*;
	logic [15:0] bend;
	logic pw;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	// Boot area end and accepted flash write or erase
	assign bend = o_option_ctrl[0] ? BOOT_END_LARGE : BOOT_END_SMALL;
	assign pw = i_clock_en && o_pm_ready && (i_pm_req.wr || i_pm_req.erase);
	property p_ack; i_clock_en && i_reg_req.valid |=> o_reg_ack; endproperty
	a_ack: assert property (p_ack) else $error("no register ack");
	property p_bank; i_clock_en && i_select_bank_one_op |=> o_bank; endproperty
	a_bank: assert property (p_bank) else $error("bank one not taken");
	property p_rst; $fell(i_sys_rst) |-> !o_bank && o_register_page_select == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_start; $rose(o_start_valid) |-> o_start_addr == (o_option_ctrl[7] ?
		RESET_VECTOR : o_option_ctrl[0] ? BOOT_VEC_LARGE : BOOT_VEC_SMALL); endproperty
	a_start: assert property (p_start) else $error("bad start address");
	property p_prot; pw && !o_option_ctrl[2] && i_pm_req.addr inside {[BOOT_AREA_START:bend]}
		|=> o_pm_ack && o_pm_refused; endproperty
	a_prot: assert property (p_prot) else $error("boot write not refused");
	property p_open; pw && o_option_ctrl[2] |=> o_pm_ack && !o_pm_refused; endproperty
	a_open: assert property (p_open) else $error("open write refused");
	property p_opt; pw && !i_prog_req.wr |=> $stable(o_option_ctrl); endproperty
	a_opt: assert property (p_opt) else $error("options moved");
	property p_vec; i_clock_en && o_pm_ready && i_pm_req.rd && !pw
		&& i_pm_req.addr <= VECTOR_AREA_END |=> o_pm_vector_area; endproperty
	a_vec: assert property (p_vec) else $error("vector area flag low");
endmodule : register_file_address_map_checker
`default_nettype wire

// File: cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
	input wire logic i_clock,
	input wire logic [7:0] i_reg_rdata,
	input wire logic i_reg_ack,
	input wire logic i_reg_unmapped,
	input wire logic [7:0] i_pm_rdata,
	input wire logic i_pm_ack,
	input wire logic i_pm_refused,
	input wire logic i_pm_vector_area,
	output var address_map_pkg::reg_req_t o_reg_req,
	output var address_map_pkg::pm_req_t o_pm_req
);
	import address_map_pkg::*;
	// Idle buses at time zero
	initial begin
		o_reg_req = '0;
		o_pm_req = '0;
	end
	// Register access, c is {write, dst, mode}; answer taken one cycle on
	task automatic reg_op(input logic [4:0] c, input logic [7:0] a, d, output logic [9:0] q);
		@(posedge i_clock) #1;
		o_reg_req = {1'b1, c, a, d};
		@(posedge i_clock) #1;
		o_reg_req = {1'b0, c, ~a, ~d};
		q = {i_reg_ack, i_reg_unmapped, i_reg_rdata};
	endtask : reg_op
	// Program access, k is {rd, wr, erase}
	task automatic pm_op(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d,
		output logic [10:0] q);
		@(posedge i_clock) #1;
		o_pm_req = {k, a, d};
		@(posedge i_clock) #1;
		o_pm_req = {3'h0, ~a, ~d};
		q = {i_pm_ack, i_pm_refused, i_pm_vector_area, i_pm_rdata};
	endtask : pm_op
endmodule : cpu_core_model
`default_nettype wire

// File: register_file_address_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module register_file_address_map_tb;
	import address_map_pkg::*;
	typedef logic [30:0] row_t;
	localparam logic [9:0] W = 10'h200;
	localparam logic [9:0] U = 10'h300;
	localparam logic [2:0] RD = 3'h4;
	localparam logic [2:0] WR = 3'h2;
	logic clock, rst, clock_en, b0, b1, bank, va, pm_ack, pm_ref, ack, unm, sv;
	logic [7:0] rdata, page, pm_rdata, octrl;
	logic [15:0] start;
	reg_req_t reg_req;
	pm_req_t pm_req;
	prog_req_t prog;
	logic [9:0] q;
	logic [10:0] p;
	int error_cnt = 0;
	int n_compared = 0;
	// {write, dst, mode}, address, data, expected {ack, unmapped, rdata}
	row_t rows[22] = '{{5'h10, 8'hDF, 8'h21, W}, {5'h18, 8'h10, 8'hA5, W},
		{5'h10, 8'h10, 8'h5A, W}, {5'h08, 8'h10, 8'h00, 10'h2A5}, {5'h00, 8'h10, 8'h00, 10'h25A},
		{5'h12, 8'hD5, 8'h11, W}, {5'h10, 8'hD5, 8'h77, W}, {5'h03, 8'hD5, 8'h00, 10'h211},
		{5'h01, 8'hD5, 8'h00, 10'h277}, {5'h00, 8'hC3, 8'h00, U}, {5'h11, 8'hC3, 8'h99, W},
		{5'h01, 8'hC3, 8'h00, 10'h299}, {5'h04, 8'hD5, 8'h00, U}, {5'h10, 8'hDF, 8'h88, W},
		{5'h10, 8'h45, 8'h12, W}, {5'h00, 8'h45, 8'h00, 10'h212}, {5'h00, 8'h46, 8'h00, U},
		{5'h02, 8'hC0, 8'h00, U}, {5'h10, 8'hDF, 8'h99, W}, {5'h00, 8'h10, 8'h00, U},
		{5'h00, 8'hDF, 8'h00, 10'h299}, {5'h10, 8'hDF, 8'h00, W}};
	register_file_address_map register_file_address_map_i (
		.i_clock(clock), .i_sys_rst(rst), .i_clock_en(clock_en), .i_reg_req(reg_req),
		.i_select_bank_zero_op(b0), .i_select_bank_one_op(b1), .i_pm_req(pm_req),
		.i_prog_req(prog), .o_reg_rdata(rdata), .o_reg_ack(ack), .o_reg_unmapped(unm),
		.o_register_page_select(page), .o_bank(bank), .o_pm_rdata(pm_rdata),
		.o_pm_ack(pm_ack), .o_pm_refused(pm_ref), .o_pm_vector_area(va), .o_pm_ready(),
		.o_start_addr(start), .o_start_valid(sv), .o_option_ctrl(octrl), .o_option_aux());
	cpu_core_model cpu_core_model_i (
		.i_clock(clock), .i_reg_rdata(rdata), .i_reg_ack(ack), .i_reg_unmapped(unm),
		.i_pm_rdata(pm_rdata), .i_pm_ack(pm_ack), .i_pm_refused(pm_ref),
		.i_pm_vector_area(va), .o_reg_req(reg_req), .o_pm_req(pm_req));
	task automatic check(input string n, input logic [19:0] s, x);
		n_compared++;
		if (s !== x) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask : check
	task automatic end_sim;
		if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// One-cycle bank op, z selects bank one
	task automatic pulse(input logic z);
		@(posedge clock) #1;
		b0 = ~z;
		b1 = z;
		@(posedge clock) #1;
		b0 = 1'b0;
		b1 = 1'b0;
	endtask : pulse
	task automatic prog_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock) #1;
		prog = {1'b1, a, d};
		@(posedge clock) #1;
		prog = {1'b0, ~a, ~d};
	endtask : prog_wr
	// Short reset, then wait out the option latch
	task automatic rst_run;
		@(posedge clock) #1;
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1 rst = 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask : rst_run
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// The run needs about 150 cycles
	initial begin
		#1000000;
		error_cnt++;
		end_sim();
	end
	initial begin
		rst = 1'b1;
		clock_en = 1'b1;
		b0 = 1'b0;
		b1 = 1'b0;
		prog = '0;
		repeat (16) @(posedge clock);
		// Load defined option bytes while reset holds, so the first latch sees no unknowns
		prog_wr(16'h003E, 8'hFF);
		prog_wr(16'h003F, 8'hFF);
		#1 rst = 1'b0;
		check("reset", {bank, page}, 9'h000);
		foreach (rows[i]) begin
			cpu_core_model_i.reg_op(rows[i][30:26], rows[i][25:18], rows[i][17:10], q);
			check("reg", q, rows[i][9:0]);
		end
		// Prime area through each addressing mode
		for (int m = 0; m < 7; m++) begin
			cpu_core_model_i.reg_op(5'h10 + 5'(m), 8'h20, 8'h40 + 8'(m), q);
			cpu_core_model_i.reg_op(5'(m), 8'h20, 8'h00, q);
			check("prime", q, {2'b10, 8'h40 + 8'(m)});
		end
		cpu_core_model_i.reg_op(5'h10, 8'hE0, 8'h01, q);
		pulse(1'b1);
		check("bank", bank, 1'b1);
		cpu_core_model_i.reg_op(5'h10, 8'hE0, 8'h02, q);
		cpu_core_model_i.reg_op(5'h00, 8'hE0, 8'h00, q);
		check("bank1", q, 10'h202);
		clock_en = 1'b0;
		pulse(1'b0);
		check("frozen", bank, 1'b1);
		clock_en = 1'b1;
		pulse(1'b0);
		cpu_core_model_i.reg_op(5'h00, 8'hE0, 8'h00, q);
		check("bank0", q, 10'h201);
		prog_wr(16'h003E, 8'hFF);
		rst_run();
		check("start", {sv, start}, 17'h10100);
		prog_wr(16'h003E, 8'h7A);
		check("opt", octrl, 8'h7A);
		rst_run();
		check("boot", {sv, start}, 17'h10500);
		cpu_core_model_i.pm_op(WR, 16'h04FF, 8'h33, p);
		check("prot", p[10:8], 3'h6);
		cpu_core_model_i.pm_op(3'h1, 16'h0300, 8'h00, p);
		check("erase", p[10:8], 3'h6);
		cpu_core_model_i.pm_op(WR, 16'hFFFF, 8'h5C, p);
		cpu_core_model_i.pm_op(RD, 16'hFFFF, 8'h00, p);
		check("top", p, 11'h45C);
		cpu_core_model_i.pm_op(WR, 16'h003E, 8'h00, p);
		check("optw", {p[10:8], octrl}, 11'h47A);
		cpu_core_model_i.pm_op(RD, 16'h003E, 8'h00, p);
		check("vec", p, 11'h500);
		prog_wr(16'h003E, 8'h7B);
		cpu_core_model_i.pm_op(WR, 16'h08FF, 8'h11, p);
		check("large", p[10:8], 3'h6);
		cpu_core_model_i.pm_op(WR, 16'h0900, 8'h11, p);
		check("past", p[10:8], 3'h4);
		prog_wr(16'h003E, 8'h7F);
		cpu_core_model_i.pm_op(WR, 16'h0200, 8'h22, p);
		check("open", p[10:8], 3'h4);
		rst_run();
		check("boot2", {sv, start}, 17'h10900);
		end_sim();
	end
endmodule : register_file_address_map_tb
bind register_file_address_map register_file_address_map_checker chk_i (.*);
`default_nettype wire
